// [verilog/bmw_defines.svh]
`ifndef BMW_DEFINES_SVH
`define BMW_DEFINES_SVH

// register byte offsets
`define BMW_OFS_MEM_WIN      12'h020
`define BMW_OFS_PREF_WIN_LO  12'h024
`define BMW_OFS_PREF_BASE_HI 12'h028
`define BMW_OFS_PREF_LIM_HI  12'h02C

// field positions inside the 32-bit words
`define BMW_BASE_LSB   4
`define BMW_BASE_MSB   15
`define BMW_LIMIT_LSB  20
`define BMW_LIMIT_MSB  31

// read-only values and reset values
`define BMW_PREF_64BIT_IND 4'h1
`define BMW_FIELD_RESET    12'h000
`define BMW_UPPER_RESET    32'h0000_0000

// assumed low bits of window bounds
`define BMW_LOW_ZERO 20'h0_0000
`define BMW_LOW_ONES 20'hF_FFFF

`endif

// [verilog/bmw_pkg.sv]
package bmw_pkg;
  typedef logic [11:0] bmw_field_t;
  typedef logic [63:0] bmw_addr_t;
  typedef enum logic [1:0] {
    BMW_HIT_NONE,
    BMW_HIT_MEM,
    BMW_HIT_PREF
  } bmw_hit_t;
endpackage : bmw_pkg

// [verilog/bmw_window_cmp.sv]
`timescale 1ns/1ps
`include "bmw_defines.svh"

module bmw_window_cmp (
  // window bounds
  input  wire bmw_pkg::bmw_addr_t winBase,
  input  wire bmw_pkg::bmw_addr_t winLimit,
  // address under test
  input  wire bmw_pkg::bmw_addr_t reqAddr,
  // result
  output wire logic               inWindow
);
  import bmw_pkg::*;

  // inclusive at both ends; base above limit gives an empty window
  assign inWindow = (reqAddr >= winBase) && (reqAddr <= winLimit);
endmodule : bmw_window_cmp

// [verilog/bmw_regs.sv]
`timescale 1ns/1ps
`include "bmw_defines.svh"

module bmw_regs (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rstn,
  input  wire logic               clkEn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // forwarding decision
  input  wire logic               reqValid,
  input  wire bmw_pkg::bmw_addr_t reqAddr,
  input  wire logic               reqPref,
  output logic                    fwdValid,
  output logic                    fwdHit,
  output bmw_pkg::bmw_hit_t       fwdWindow
);
  import bmw_pkg::*;

  bmw_field_t memBase_q;
  bmw_field_t memLimit_q;
  bmw_field_t prefBase_q;
  bmw_field_t prefLimit_q;
  logic [31:0] prefBaseHi_q;
  logic [31:0] prefLimitHi_q;

  // apb decode; one wait-free access phase
  wire        setupPh   = psel && !penable;
  wire        accessPh  = psel && penable;
  wire        selMem    = (paddr == `BMW_OFS_MEM_WIN);
  wire        selPrefLo = (paddr == `BMW_OFS_PREF_WIN_LO);
  wire        selBaseHi = (paddr == `BMW_OFS_PREF_BASE_HI);
  wire        selLimHi  = (paddr == `BMW_OFS_PREF_LIM_HI);
  wire        mapped    = selMem || selPrefLo || selBaseHi || selLimHi;
  wire        wrStb     = accessPh && pready && pwrite && mapped;

  // merge write data with byte strobes against current word
  wire [31:0] strbMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [31:0] memWord;
  wire [31:0] prefWord;
  wire [31:0] curWord;
  wire [31:0] newWord;

  assign memWord  = {memLimit_q, 4'h0, memBase_q, 4'h0};
  assign prefWord = {prefLimit_q, `BMW_PREF_64BIT_IND,
                     prefBase_q, `BMW_PREF_64BIT_IND};
  assign curWord  = selMem    ? memWord :
                    selPrefLo ? prefWord :
                    selBaseHi ? prefBaseHi_q :
                    selLimHi  ? prefLimitHi_q : 32'h0000_0000;
  assign newWord  = (pwdata & strbMask) | (curWord & ~strbMask);

  // writable fields only; nibbles at 3:0 and 19:16 of the memory and prefetchable window words are never stored
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      memBase_q     <= `BMW_FIELD_RESET;
      memLimit_q    <= `BMW_FIELD_RESET;
      prefBase_q    <= `BMW_FIELD_RESET;
      prefLimit_q   <= `BMW_FIELD_RESET;
      prefBaseHi_q  <= `BMW_UPPER_RESET;
      prefLimitHi_q <= `BMW_UPPER_RESET;
    end else if (clkEn && wrStb) begin
      if (selMem) begin
        memBase_q  <= newWord[`BMW_BASE_MSB:`BMW_BASE_LSB];
        memLimit_q <= newWord[`BMW_LIMIT_MSB:`BMW_LIMIT_LSB];
      end
      if (selPrefLo) begin
        prefBase_q  <= newWord[`BMW_BASE_MSB:`BMW_BASE_LSB];
        prefLimit_q <= newWord[`BMW_LIMIT_MSB:`BMW_LIMIT_LSB];
      end
      if (selBaseHi) begin
        prefBaseHi_q <= newWord;
      end
      if (selLimHi) begin
        prefLimitHi_q <= newWord;
      end
    end
  end

  // pready rises in the access phase that follows one setup cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clkEn) begin
      pready  <= setupPh;
      pslverr <= setupPh && !mapped;
      // unmapped reads return zero along with the error
      prdata  <= (setupPh && !pwrite) ? curWord : 32'h0000_0000;
    end
  end

  // window bounds
  wire bmw_addr_t memLo   = {32'h0000_0000, memBase_q, `BMW_LOW_ZERO};
  wire bmw_addr_t memHi   = {32'h0000_0000, memLimit_q, `BMW_LOW_ONES};
  wire bmw_addr_t prefLo  = {prefBaseHi_q, prefBase_q, `BMW_LOW_ZERO};
  wire bmw_addr_t prefHi  = {prefLimitHi_q, prefLimit_q, `BMW_LOW_ONES};
  wire            memIn;
  wire            prefIn;

  bmw_window_cmp u_memCmp (
    .winBase  (memLo),
    .winLimit (memHi),
    .reqAddr  (reqAddr),
    .inWindow (memIn)
  );

  bmw_window_cmp u_prefCmp (
    .winBase  (prefLo),
    .winLimit (prefHi),
    .reqAddr  (reqAddr),
    .inWindow (prefIn)
  );

  // prefetchable requests try their own window first, then the plain one
  wire bmw_hit_t hitSel = (reqPref && prefIn) ? BMW_HIT_PREF :
                          memIn               ? BMW_HIT_MEM  :
                          (prefIn ? BMW_HIT_PREF : BMW_HIT_NONE);

  // registered decision; one cycle after the request
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fwdValid  <= 1'b0;
      fwdHit    <= 1'b0;
      fwdWindow <= BMW_HIT_NONE;
    end else if (clkEn) begin
      fwdValid  <= reqValid;
      fwdHit    <= reqValid && (hitSel != BMW_HIT_NONE);
      fwdWindow <= reqValid ? hitSel : BMW_HIT_NONE;
    end
  end

  // checks
  low_nibble_a: assert property (@(posedge core_clk) disable iff (!rstn)
    pready && selPrefLo && !pwrite && !pslverr |->
      prdata[3:0] == `BMW_PREF_64BIT_IND && prdata[19:16] == `BMW_PREF_64BIT_IND)
    else $error("prefetchable indicator nibble wrong");

  mem_rsvd_a: assert property (@(posedge core_clk) disable iff (!rstn)
    pready && selMem && !pwrite |-> prdata[3:0] == 4'h0 && prdata[19:16] == 4'h0)
    else $error("memory reserved nibble not zero");

  apb_ready_a: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && setupPh |=> pready)
    else $error("no ready after setup");

  base_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && wrStb && selMem && (&pstrb) |=> memBase_q == $past(pwdata[15:4]))
    else $error("memory base write lost");

  limit_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && wrStb && selPrefLo && (&pstrb) |=> prefLimit_q == $past(pwdata[31:20]))
    else $error("prefetchable limit write lost");

  upper_base_a: assert property (@(posedge core_clk) disable iff (!rstn)
    prefLo[63:32] == prefBaseHi_q && prefLo[19:0] == `BMW_LOW_ZERO)
    else $error("prefetchable bottom formed wrongly");

  mem_top_a: assert property (@(posedge core_clk) disable iff (!rstn)
    memHi[19:0] == `BMW_LOW_ONES && memLo[19:0] == `BMW_LOW_ZERO)
    else $error("memory bounds formed wrongly");

  fwd_hit_a: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && reqValid && reqAddr >= memLo && reqAddr <= memHi |=> fwdHit && fwdValid)
    else $error("address inside memory window not forwarded");

  pref_hit_a: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && reqValid && reqPref && reqAddr >= prefLo && reqAddr <= prefHi
      |=> fwdWindow == BMW_HIT_PREF)
    else $error("prefetchable hit missed");

  miss_a: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && reqValid && !(reqAddr >= memLo && reqAddr <= memHi)
      && !(reqAddr >= prefLo && reqAddr <= prefHi) |=> !fwdHit)
    else $error("address outside windows forwarded");

  // a frozen clock enable must hold every flop, bus answer included
  freeze_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !clkEn |=> $stable(pready) && $stable(fwdValid) && $stable(memBase_q))
    else $error("state moved with clock enable low");

  unmapped_err_a: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && setupPh && !mapped |=> pslverr && pready && prdata == 32'h0000_0000)
    else $error("unmapped access not flagged");

  upper_limit_a: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn && wrStb && selLimHi && (&pstrb) |=> prefLimitHi_q == $past(pwdata))
    else $error("upper limit write lost");

  fwd_valid_a: assert property (@(posedge core_clk) disable iff (!rstn)
    clkEn |=> fwdValid == $past(reqValid))
    else $error("decision strobe not one cycle after request");
endmodule : bmw_regs

// [verification/bmw_host_model.sv]
`timescale 1ns/1ps

module bmw_host_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // bench request
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wdata,
  output logic             done,
  output logic [31:0]      rdata,
  output logic             err,
  // apb master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      {psel, penable, pwrite, done, err} <= 5'h00;
      paddr  <= 12'h000;
      pwdata <= 32'h0000_0000;
      rdata  <= 32'h0000_0000;
    end else begin
      done <= 1'b0;
      if (go && !psel) begin
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= addr;
        pwdata <= wdata;
      end else if (psel && !penable) begin
        penable <= 1'b1;
      end else if (psel && pready) begin
        // released bus must not keep showing the old request
        {psel, penable} <= 2'b00;
        paddr  <= ~paddr;
        pwdata <= ~pwdata;
        rdata  <= prdata;
        err    <= pslverr;
        done   <= 1'b1;
      end
    end
  end
endmodule : bmw_host_model

// [verification/tb_bmw_regs.sv]
`timescale 1ns/1ps

module tb_bmw_regs;
  import bmw_pkg::*;
  logic                core_clk = 1'b0;
  logic                rstn     = 1'b0;
  logic                go       = 1'b0;
  logic                wr       = 1'b0;
  logic [11:0]         addr     = 12'h000;
  logic [31:0]         wdata    = 32'h0000_0000;
  logic                reqValid = 1'b0;
  logic                reqPref  = 1'b0;
  logic                clkEn    = 1'b1;
  logic [3:0]          pstrb    = 4'hF;
  bmw_addr_t           reqAddr  = 64'h0;
  logic [31:0]         rdata, prdata, pwdata;
  logic [11:0]         paddr;
  logic                psel, penable, pwrite, pready, pslverr, done, err, fwdValid, fwdHit;
  bmw_hit_t            fwdWindow;
  int                  errors   = 0;
  int                  checked  = 0;

  always #2.5 core_clk = ~core_clk;

  bmw_regs uut (.core_clk(core_clk), .rstn(rstn), .clkEn(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .reqValid(reqValid),
    .reqAddr(reqAddr), .reqPref(reqPref), .fwdValid(fwdValid), .fwdHit(fwdHit),
    .fwdWindow(fwdWindow));

  bmw_host_model host (.core_clk(core_clk), .rstn(rstn), .go(go), .wr(wr), .addr(addr),
    .wdata(wdata), .done(done), .rdata(rdata), .err(err), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr));

  task results;
    if (errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    go <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    go <= 1'b0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 20);
    if (n >= 20) errors++;
  endtask : xfer

  task rd(input logic [11:0] a, input logic [31:0] exp, input logic expErr);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rdata, exp);
    chk({31'h0, err}, {31'h0, expErr});
  endtask : rd

  // exp packs {valid, hit, window}
  task fwd(input bmw_addr_t a, input logic p, input logic [3:0] exp);
    @(posedge core_clk);
    reqValid <= 1'b1;
    reqAddr <= a;
    reqPref <= p;
    @(posedge core_clk);
    reqValid <= 1'b0;
    #1;
    chk({28'h0, fwdValid, fwdHit, fwdWindow}, {28'h0, exp});
  endtask : fwd

  initial begin
    #100000;
    errors++;
    results();
  end

  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    rd(12'h020, 32'h0000_0000, 1'b0);
    rd(12'h024, 32'h0001_0001, 1'b0);
    rd(12'h028, 32'h0000_0000, 1'b0);
    rd(12'h02C, 32'h0000_0000, 1'b0);
    rd(12'h030, 32'h0000_0000, 1'b1);
    xfer(1'b1, 12'h020, 32'hFFFF_FFFF);
    rd(12'h020, 32'hFFF0_FFF0, 1'b0);
    xfer(1'b1, 12'h024, 32'hFFFF_FFFE);
    rd(12'h024, 32'hFFF1_FFF1, 1'b0);
    xfer(1'b1, 12'h020, 32'h1FF0_1000);
    fwd(64'h0000_0000_1000_0000, 1'b0, 4'hD);
    fwd(64'h0000_0000_0FFF_FFFF, 1'b0, 4'h8);
    fwd(64'h0000_0000_1FFF_FFFF, 1'b0, 4'hD);
    fwd(64'h0000_0000_2000_0000, 1'b0, 4'h8);
    xfer(1'b1, 12'h024, 32'h3000_2000);
    xfer(1'b1, 12'h028, 32'h0000_0001);
    xfer(1'b1, 12'h02C, 32'h0000_0001);
    rd(12'h028, 32'h0000_0001, 1'b0);
    rd(12'h02C, 32'h0000_0001, 1'b0);
    fwd(64'h0000_0001_2000_0000, 1'b1, 4'hE);
    fwd(64'h0000_0001_2000_0000, 1'b0, 4'hE);
    fwd(64'h0000_0000_2000_0000, 1'b1, 4'h8);
    fwd(64'h0000_0001_1FFF_FFFF, 1'b1, 4'h8);
    fwd(64'h0000_0001_300F_FFFF, 1'b1, 4'hE);
    fwd(64'h0000_0001_3010_0000, 1'b1, 4'h8);
    // partial strobes keep the untouched bytes
    pstrb <= 4'h3;
    xfer(1'b1, 12'h028, 32'hFFFF_FFFF);
    pstrb <= 4'hF;
    rd(12'h028, 32'h0000_FFFF, 1'b0);
    // frozen clock enable: no decision strobe appears
    @(posedge core_clk);
    clkEn <= 1'b0;
    fwd(64'h0000_0000_1000_0000, 1'b0, 4'h0);
    clkEn <= 1'b1;
    fwd(64'h0000_0000_1000_0000, 1'b0, 4'hD);
    results();
  end
endmodule : tb_bmw_regs
